// file: verilog/vsf_pkg.sv
// shared constants and carrier types for the video framing configuration host
package vsf_pkg;

  // device register map (byte addresses on the device port)
  localparam logic [11:0] VSF_DEV_MISC2      = 12'h1A8;
  localparam logic [11:0] VSF_DEV_M_VALUE    = 12'h1AC;
  localparam logic [11:0] VSF_DEV_UNIT_SIZE  = 12'h1B0;
  localparam logic [11:0] VSF_DEV_N_VALUE    = 12'h1B4;
  localparam logic [11:0] VSF_DEV_PIX_COUNT  = 12'h1B8;
  localparam logic [11:0] VSF_DEV_LANE_WORDS = 12'h1BC;
  localparam logic [11:0] VSF_DEV_INTERLACE  = 12'h1C0;
  localparam logic [11:0] VSF_DEV_WHOLE      = 12'h1C4;
  localparam logic [11:0] VSF_DEV_FRACTION   = 12'h1C8;
  localparam logic [11:0] VSF_DEV_INIT_WAIT  = 12'h1CC;

  // own register map, seen by software
  localparam logic [7:0] VSF_REG_CTRL      = 8'h00;
  localparam logic [7:0] VSF_REG_CFG       = 8'h04;
  localparam logic [7:0] VSF_REG_LINE      = 8'h08;
  localparam logic [7:0] VSF_REG_UNIT_SIZE = 8'h0C;
  localparam logic [7:0] VSF_REG_LINK_BANDWIDTH   = 8'h10;
  localparam logic [7:0] VSF_REG_VIDEO_BANDWIDTH  = 8'h14;
  localparam logic [7:0] VSF_REG_M_VALUE   = 8'h18;
  localparam logic [7:0] VSF_REG_N_VALUE   = 8'h1C;
  localparam logic [7:0] VSF_REG_STATUS    = 8'h20;
  localparam logic [7:0] VSF_REG_RESULT    = 8'h24;
  localparam logic [7:0] VSF_REG_LANE_CNT  = 8'h28;

  // field positions
  localparam int VSF_CTRL_GO      = 0;
  localparam int VSF_CFG_PIX_LO   = 0;
  localparam int VSF_CFG_LANE_LO  = 3;
  localparam int VSF_CFG_SYNC     = 5;
  localparam int VSF_CFG_ILACE    = 6;
  localparam int VSF_CFG_MISC_LO  = 8;
  localparam int VSF_ST_BUSY      = 0;
  localparam int VSF_ST_DONE      = 1;
  localparam int VSF_ST_CFG_ERR   = 2;
  localparam int VSF_ST_BUS_ERR   = 3;

  // reset values and limits
  localparam logic [6:0]  VSF_UNIT_RESET = 7'h40;
  localparam logic [6:0]  VSF_UNIT_MIN   = 7'h20;
  localparam logic [6:0]  VSF_UNIT_MAX   = 7'h40;
  localparam logic [7:0]  VSF_MISC2_MASK = 8'h07;
  localparam logic [7:0]  VSF_WAIT_LONG  = 8'h40;
  localparam logic [7:0]  VSF_WHOLE_LOW  = 8'h04;
  localparam logic [15:0] VSF_FRAC_SCALE = 16'h03E8;
  localparam logic [4:0]  VSF_WORD_ROUND = 5'h0F;
  localparam int          VSF_WORD_SHIFT = 4;
  localparam logic [3:0]  VSF_LAST_STEP  = 4'hB;

  typedef struct packed {
    logic [11:0] addr;
    logic        write;
    logic [31:0] wdata;
  } vsf_req_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic        err;
  } vsf_rsp_t;

endpackage

// file: verilog/vsf_apb_master.sv
// one-transfer apb master toward the framing device
`timescale 1ns/1ns
`default_nettype none
module vsf_apb_master
  import vsf_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // request side
  input  wire logic        start,
  input  wire vsf_req_t    req,
  output var  logic        done_q,
  output var  vsf_rsp_t    rsp_q,
  // device port
  output var  logic        m_psel_q,
  output var  logic        m_penable_q,
  output var  logic [11:0] m_paddr_q,
  output var  logic        m_pwrite_q,
  output var  logic [31:0] m_pwdata_q,
  input  wire logic        m_pready,
  input  wire logic [31:0] m_prdata,
  input  wire logic        m_pslverr
);

  typedef enum logic [1:0] {
    VSF_M_IDLE   = 2'b00,
    VSF_M_SETUP  = 2'b01,
    VSF_M_ACCESS = 2'b10
  } vsf_mstate_t;

  vsf_mstate_t state_q;

  wire logic sampled = (state_q == VSF_M_ACCESS) && m_pready;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q     <= VSF_M_IDLE;
      m_psel_q    <= 1'b0;
      m_penable_q <= 1'b0;
      m_paddr_q   <= 12'h000;
      m_pwrite_q  <= 1'b0;
      m_pwdata_q  <= 32'h0000_0000;
      done_q      <= 1'b0;
      rsp_q       <= '0;
    end
    else
    begin
      done_q <= sampled;
      unique case (state_q)
        VSF_M_IDLE:
        begin
          if (start)
          begin
            state_q    <= VSF_M_SETUP;
            m_psel_q   <= 1'b1;
            m_paddr_q  <= req.addr;
            m_pwrite_q <= req.write;
            m_pwdata_q <= req.wdata;
          end
        end
        VSF_M_SETUP:
        begin
          state_q     <= VSF_M_ACCESS;
          m_penable_q <= 1'b1;
        end
        VSF_M_ACCESS:
        begin
          // request held until the slave answers; no local timeout
          if (m_pready)
          begin
            state_q     <= VSF_M_IDLE;
            m_psel_q    <= 1'b0;
            m_penable_q <= 1'b0;
            rsp_q.rdata <= m_pwrite_q ? rsp_q.rdata : m_prdata;
            rsp_q.err   <= m_pslverr;
          end
        end
        default:
        begin
          state_q <= VSF_M_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// file: verilog/vsf_host.sv
// host controller that computes and programs the video framing configuration
//
// What this block does
// - in synchronous clocking mode software writes the 24-bit video M value.
// - in synchronous clocking mode software writes the 24-bit video N value.
// - a fixed unit size between 32 and 64 should be programmed.
// - words per line is pixels times bits per pixel over 16, rounded up.
// - one lane: lane word count is words per line minus 1.
// - two lanes: words plus words mod 2, minus 2.
// - four lanes: words plus words mod 4, minus 4.
// - the interlace bit is set whenever the source video is interlaced.
// - whole bytes is the integer part of link over video bandwidth times unit size.
// - fraction bytes is the fractional part of that product times 1000.
`timescale 1ns/1ns
`default_nettype none
module vsf_host
  import vsf_pkg::*;
#(
  parameter int DW = 40
)
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // software apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata_q,
  output var  logic        pready_q,
  output var  logic        pslverr_q,
  // device apb master
  output wire logic        m_psel,
  output wire logic        m_penable,
  output wire logic [11:0] m_paddr,
  output wire logic        m_pwrite,
  output wire logic [31:0] m_pwdata,
  input  wire logic        m_pready,
  input  wire logic [31:0] m_prdata,
  input  wire logic        m_pslverr
);

  typedef enum logic [2:0] {
    VSF_IDLE  = 3'b000,
    VSF_DIV1  = 3'b001,
    VSF_DIV2  = 3'b010,
    VSF_CALC  = 3'b011,
    VSF_ISSUE = 3'b100,
    VSF_WAIT  = 3'b101
  } vsf_state_t;

  // software registers
  logic [15:0] cfg_q;
  logic [31:0] line_q;
  logic [6:0]  unit_q;
  logic [23:0] link_bandwidth_q;
  logic [23:0] video_bandwidth_q;
  logic [23:0] m_val_q;
  logic [23:0] n_val_q;
  logic        done_flag_q;
  logic        cfg_err_q;
  logic        bus_err_q;
  // computed values
  logic [7:0]  whole_q;
  logic [9:0]  frac_q;
  logic [31:0] lane_cnt_q;
  logic [7:0]  wait_q;
  // sequencer and divider
  vsf_state_t  state_q;
  logic [3:0]  step_q;
  logic [DW-1:0] quo_q;
  logic [DW-1:0] rem_q;
  logic [DW-1:0] dvs_q;
  logic [5:0]  bit_q;
  logic        start_q;
  logic        mdone;
  vsf_rsp_t    mrsp;

  // software bus decode
  wire logic acc     = psel && penable && !pready_q;
  wire logic wr_acc  = psel && penable && pready_q && pwrite;
  wire logic hit_ctl = paddr == VSF_REG_CTRL;
  wire logic mapped  = (paddr[1:0] == 2'b00) && (paddr <= VSF_REG_LANE_CNT);
  wire logic busy    = state_q != VSF_IDLE;
  wire logic go      = wr_acc && hit_ctl && pwdata[VSF_CTRL_GO] && !busy;

  wire logic [2:0] pix_code = cfg_q[VSF_CFG_PIX_LO +: 3];
  wire logic [1:0] lane_sel = cfg_q[VSF_CFG_LANE_LO +: 2];
  wire logic       sync_md  = cfg_q[VSF_CFG_SYNC];
  wire logic       ilace    = cfg_q[VSF_CFG_ILACE];
  wire logic [7:0] misc2    = cfg_q[VSF_CFG_MISC_LO +: 8] & VSF_MISC2_MASK;

  // configuration checks before anything reaches the device
  wire logic pix_ok  = (pix_code == 3'h1) || (pix_code == 3'h2) || (pix_code == 3'h4);
  wire logic unit_ok = (unit_q >= VSF_UNIT_MIN) && (unit_q <= VSF_UNIT_MAX);
  wire logic cfg_ok  = pix_ok && unit_ok && (lane_sel != 2'b11) && (video_bandwidth_q != 24'h000000);

  wire logic [7:0] rd_status = {4'h0, bus_err_q, cfg_err_q, done_flag_q, busy};

  wire logic [31:0] rd_mux =
    (paddr == VSF_REG_CFG)       ? {16'h0000, cfg_q} :
    (paddr == VSF_REG_LINE)      ? line_q :
    (paddr == VSF_REG_UNIT_SIZE) ? {25'h0000000, unit_q} :
    (paddr == VSF_REG_LINK_BANDWIDTH)   ? {8'h00, link_bandwidth_q} :
    (paddr == VSF_REG_VIDEO_BANDWIDTH)  ? {8'h00, video_bandwidth_q} :
    (paddr == VSF_REG_M_VALUE)   ? {8'h00, m_val_q} :
    (paddr == VSF_REG_N_VALUE)   ? {8'h00, n_val_q} :
    (paddr == VSF_REG_STATUS)    ? {24'h000000, rd_status} :
    (paddr == VSF_REG_RESULT)    ? {6'h00, frac_q, wait_q, whole_q} :
    (paddr == VSF_REG_LANE_CNT)  ? lane_cnt_q :
    32'h0000_0000;

  // words per line on the 16-bit datapath, rounded up
  wire logic [23:0] bits_line = line_q[15:0] * line_q[23:16];
  wire logic [24:0] bits_rnd  = {1'b0, bits_line} + {20'h00000, VSF_WORD_ROUND};
  wire logic [31:0] wpl       = {11'h000, bits_rnd[24:VSF_WORD_SHIFT]};

  // lane word count, as the device expects it per lane
  wire logic [31:0] cnt_one  = wpl - 32'h0000_0001;
  wire logic [31:0] cnt_two  = wpl + {31'h00000000, wpl[0]} - 32'h0000_0002;
  wire logic [31:0] cnt_four = wpl + {30'h00000000, wpl[1:0]} - 32'h0000_0004;
  wire logic [31:0] lane_cnt = (lane_sel == 2'b00) ? cnt_one :
                               (lane_sel == 2'b01) ? cnt_two : cnt_four;

  // restoring divider step
  wire logic [DW:0]   shl  = {rem_q, quo_q[DW-1]};
  wire logic [DW:0]   dif  = shl - {1'b0, dvs_q};
  wire logic          take = !dif[DW];
  wire logic [DW-1:0] rem_d = take ? dif[DW-1:0] : shl[DW-1:0];
  wire logic [DW-1:0] quo_d = {quo_q[DW-2:0], take};
  wire logic          div_last = bit_q == 6'(DW - 1);

  // numerator link bandwidth times unit size; second pass scales the remainder
  wire logic [DW-1:0] num_one = DW'(link_bandwidth_q * unit_q);
  wire logic [DW-1:0] num_two = DW'(rem_d * VSF_FRAC_SCALE);

  // initial wait derived from the whole bytes result
  wire logic [7:0] wait_d = (whole_q <= VSF_WHOLE_LOW) ? VSF_WAIT_LONG :
                            ({1'b0, unit_q} - whole_q);

  // device transfer list, selected by step
  wire logic [6:0] unit_even = {unit_q[6:1], 1'b0};
  wire logic [11:0] step_addr =
    (step_q == 4'h0) ? VSF_DEV_MISC2 :
    (step_q == 4'h1) ? VSF_DEV_M_VALUE :
    (step_q == 4'h2) ? VSF_DEV_UNIT_SIZE :
    (step_q == 4'h3) ? VSF_DEV_N_VALUE :
    (step_q == 4'h4) ? VSF_DEV_PIX_COUNT :
    (step_q == 4'h5) ? VSF_DEV_LANE_WORDS :
    (step_q == 4'h6) ? VSF_DEV_INTERLACE :
    (step_q == 4'h7) ? VSF_DEV_WHOLE :
    (step_q == 4'h8) ? VSF_DEV_FRACTION :
    (step_q == 4'h9) ? VSF_DEV_INIT_WAIT :
    (step_q == 4'hA) ? VSF_DEV_M_VALUE : VSF_DEV_N_VALUE;
  wire logic [31:0] step_data =
    (step_q == 4'h0) ? {24'h000000, misc2} :
    (step_q == 4'h1) ? {8'h00, m_val_q} :
    (step_q == 4'h2) ? {25'h0000000, unit_even} :
    (step_q == 4'h3) ? {8'h00, n_val_q} :
    (step_q == 4'h4) ? {29'h00000000, pix_code} :
    (step_q == 4'h5) ? lane_cnt_q :
    (step_q == 4'h6) ? {31'h00000000, ilace} :
    (step_q == 4'h7) ? {24'h000000, whole_q} :
    (step_q == 4'h8) ? {22'h000000, frac_q} :
    (step_q == 4'h9) ? {24'h000000, wait_q} : 32'h0000_0000;
  wire logic step_rd = step_q >= 4'hA;
  // m and n are written only in synchronous mode, read back only in asynchronous mode
  wire logic step_mn   = (step_q == 4'h1) || (step_q == 4'h3);
  wire logic step_skip = (step_mn && !sync_md) || (step_rd && sync_md);
  wire vsf_req_t mreq = '{addr: step_addr, write: !step_rd, wdata: step_data};

  // software slave: one wait state, writes land when pready is high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= acc;
      pslverr_q <= acc && !mapped;
      prdata_q  <= (acc && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // software-written configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_q      <= 16'h0000;
      line_q     <= 32'h0000_0000;
      unit_q     <= VSF_UNIT_RESET;
      link_bandwidth_q  <= 24'h000000;
      video_bandwidth_q <= 24'h000000;
    end
    else if (wr_acc && !busy)
    begin
      if (paddr == VSF_REG_CFG)       cfg_q      <= pwdata[15:0];
      if (paddr == VSF_REG_LINE)      line_q     <= pwdata;
      if (paddr == VSF_REG_UNIT_SIZE) unit_q     <= pwdata[6:0];
      if (paddr == VSF_REG_LINK_BANDWIDTH)   link_bandwidth_q  <= pwdata[23:0];
      if (paddr == VSF_REG_VIDEO_BANDWIDTH)  video_bandwidth_q <= pwdata[23:0];
    end
  end

  // m and n: software value, or the device's own figure read back
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      m_val_q <= 24'h000000;
      n_val_q <= 24'h000000;
    end
    else if (mdone && step_rd && state_q == VSF_WAIT)
    begin
      if (step_q == 4'hA) m_val_q <= mrsp.rdata[23:0];
      else                n_val_q <= mrsp.rdata[23:0];
    end
    else if (wr_acc && !busy)
    begin
      if (paddr == VSF_REG_M_VALUE) m_val_q <= pwdata[23:0];
      if (paddr == VSF_REG_N_VALUE) n_val_q <= pwdata[23:0];
    end
  end

  // sequencer: check, divide twice, compute, then program the device
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q     <= VSF_IDLE;
      step_q      <= 4'h0;
      start_q     <= 1'b0;
      done_flag_q <= 1'b0;
      cfg_err_q   <= 1'b0;
      bus_err_q   <= 1'b0;
      quo_q       <= '0;
      rem_q       <= '0;
      dvs_q       <= '0;
      bit_q       <= 6'h00;
      whole_q     <= 8'h00;
      frac_q      <= 10'h000;
      lane_cnt_q  <= 32'h0000_0000;
      wait_q      <= 8'h00;
    end
    else
    begin
      start_q <= 1'b0;
      unique case (state_q)
        VSF_IDLE:
        begin
          if (go)
          begin
            done_flag_q <= !cfg_ok;
            cfg_err_q   <= !cfg_ok;
            bus_err_q   <= 1'b0;
            state_q     <= cfg_ok ? VSF_DIV1 : VSF_IDLE;
            quo_q       <= num_one;
            rem_q       <= '0;
            dvs_q       <= DW'(video_bandwidth_q);
            bit_q       <= 6'h00;
          end
        end
        VSF_DIV1:
        begin
          quo_q <= quo_d;
          rem_q <= rem_d;
          bit_q <= bit_q + 6'h01;
          if (div_last)
          begin
            whole_q <= quo_d[7:0];
            quo_q   <= num_two;
            rem_q   <= '0;
            bit_q   <= 6'h00;
            state_q <= VSF_DIV2;
          end
        end
        VSF_DIV2:
        begin
          quo_q <= quo_d;
          rem_q <= rem_d;
          bit_q <= bit_q + 6'h01;
          if (div_last)
          begin
            frac_q  <= quo_d[9:0];
            state_q <= VSF_CALC;
          end
        end
        VSF_CALC:
        begin
          lane_cnt_q <= lane_cnt;
          wait_q     <= wait_d;
          step_q     <= 4'h0;
          state_q    <= VSF_ISSUE;
        end
        VSF_ISSUE:
        begin
          if (step_skip)
          begin
            step_q  <= step_q + 4'h1;
            state_q <= (step_q == VSF_LAST_STEP) ? VSF_IDLE : VSF_ISSUE;
            done_flag_q <= step_q == VSF_LAST_STEP;
          end
          else
          begin
            start_q <= 1'b1;
            state_q <= VSF_WAIT;
          end
        end
        VSF_WAIT:
        begin
          if (mdone)
          begin
            bus_err_q <= bus_err_q | mrsp.err;
            step_q    <= step_q + 4'h1;
            state_q   <= (step_q == VSF_LAST_STEP) ? VSF_IDLE : VSF_ISSUE;
            done_flag_q <= step_q == VSF_LAST_STEP;
          end
        end
        default:
        begin
          state_q <= VSF_IDLE;
        end
      endcase
    end
  end

  vsf_apb_master u_master (
    .pclk        (pclk),
    .presetn     (presetn),
    .start       (start_q),
    .req         (mreq),
    .done_q      (mdone),
    .rsp_q       (mrsp),
    .m_psel_q    (m_psel),
    .m_penable_q (m_penable),
    .m_paddr_q   (m_paddr),
    .m_pwrite_q  (m_pwrite),
    .m_pwdata_q  (m_pwdata),
    .m_pready    (m_pready),
    .m_prdata    (m_prdata),
    .m_pslverr   (m_pslverr)
  );

endmodule
`default_nettype wire

// file: tb/vsf_host_checker.sv
// port assertions for the framing configuration host
`timescale 1ns/1ns
`default_nettype none
module vsf_host_checker
  import vsf_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // software port
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata_q,
  input wire logic        pready_q,
  input wire logic        pslverr_q,
  // device port
  input wire logic        m_psel,
  input wire logic        m_penable,
  input wire logic [11:0] m_paddr,
  input wire logic        m_pwrite,
  input wire logic [31:0] m_pwdata,
  input wire logic        m_pready
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [7:0] whole_q;
  wire        unmapped = (paddr[1:0] != 2'h0) || (paddr > 8'h28);
  wire        dev_wr   = m_psel && m_penable && m_pready && m_pwrite;
  // whole bytes seen on the wire, needed to judge the wait that follows it
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      whole_q <= 8'h00;
    else if (dev_wr && m_paddr == VSF_DEV_WHOLE)
      whole_q <= m_pwdata[7:0];
  sequence s_setup;
    m_psel && !m_penable;
  endsequence
  sequence s_access;
    m_psel && m_penable;
  endsequence
  AST_SW_ONE_WAIT: assert property (psel && penable && !pready_q |=> pready_q)
    else $error("slave answer late");
  AST_SW_PULSE: assert property (pready_q |=> !pready_q)
    else $error("ready longer than a cycle");
  AST_SW_DECODE: assert property (pready_q |-> pslverr_q == unmapped)
    else $error("error flag wrong");
  AST_SW_RDATA_ZERO: assert property (!pready_q || pwrite || pslverr_q |-> prdata_q == 32'h0)
    else $error("read data not zero");
  AST_DEV_SETUP: assert property (s_setup |=> s_access)
    else $error("device access not after setup");
  AST_DEV_HOLD: assert property ((s_access and !m_pready) |=> (s_access and $stable(m_paddr) and $stable(m_pwdata)))
    else $error("device request moved");
  AST_DEV_RELEASE: assert property ((s_access and m_pready) |=> !m_psel && !m_penable)
    else $error("device request not released");
  AST_DEV_UNIT: assert property (dev_wr && m_paddr == VSF_DEV_UNIT_SIZE |-> m_pwdata[0] == 1'b0)
    else $error("odd unit size written");
  AST_DEV_MISC: assert property (dev_wr && m_paddr == VSF_DEV_MISC2
    |-> m_pwdata[31:3] == 29'h0)
    else $error("reserved misc bits written");
  AST_DEV_PIX: assert property (dev_wr && m_paddr == VSF_DEV_PIX_COUNT |-> m_pwdata inside {1, 2, 4})
    else $error("bad pixel code written");
  AST_DEV_WAIT: assert property (dev_wr && m_paddr == VSF_DEV_INIT_WAIT && whole_q <= 8'h04
    |-> m_pwdata == 32'h40)
    else $error("short wait wrong");
endmodule
bind vsf_host vsf_host_checker vsf_host_checker_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q), .m_psel(m_psel), .m_penable(m_penable),
  .m_paddr(m_paddr), .m_pwrite(m_pwrite), .m_pwdata(m_pwdata), .m_pready(m_pready)
);
`default_nettype wire

// file: tb/vsf_dev_model.sv
// behavioural model of the framing configuration device
`timescale 1ns/1ns
`default_nettype none
module vsf_dev_model
  import vsf_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // device port
  input  wire logic        m_psel,
  input  wire logic        m_penable,
  input  wire logic [11:0] m_paddr,
  input  wire logic        m_pwrite,
  input  wire logic [31:0] m_pwdata,
  output wire logic        m_pready,
  output wire logic [31:0] m_prdata,
  output wire logic        m_pslverr,
  // scenario controls
  input  wire logic [3:0]  wait_cycles,
  input  wire logic [11:0] err_addr,
  input  wire logic        async_mode
);
  localparam logic [23:0] COMP_M = 24'h2A4E11;
  localparam logic [23:0] COMP_N = 24'h08CA00;
  logic [31:0] regs   [0:9];
  int          wr_cnt [0:9];
  logic [3:0]  cnt_q;
  wire         hit = (m_paddr >= VSF_DEV_MISC2) && (m_paddr <= VSF_DEV_INIT_WAIT) && (m_paddr[1:0] == 2'h0);
  wire  [3:0]  idx = 4'((m_paddr - VSF_DEV_MISC2) >> 2);
  wire  [31:0] rd  = !hit ? 32'h0 : (async_mode && idx == 4'h1) ? {8'h00, COMP_M} :
                     (async_mode && idx == 4'h3) ? {8'h00, COMP_N} : regs[idx];
  wire  [31:0] keep = (idx == 4'h0) ? 32'h07 : (idx == 4'h2) ? 32'h7E :
                      (idx == 4'h4) ? 32'h07 : (idx == 4'h6) ? 32'h01 : 32'hFFFFFFFF;
  assign m_pready  = m_psel && m_penable && (cnt_q == wait_cycles);
  assign m_pslverr = m_pready && (!hit || m_paddr == err_addr);
  // a released read bus shows the inverse, so stale data never passes
  assign m_prdata  = m_pready ? rd : ~rd;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cnt_q <= 4'h0;
      for (int i = 0; i < 10; i++)
      begin
        regs[i]   <= (i == 2) ? 32'h40 : 32'h0;
        wr_cnt[i] <= 0;
      end
    end
    else
    begin
      cnt_q <= (m_psel && m_penable && !m_pready) ? cnt_q + 4'h1 : 4'h0;
      if (m_pready && m_pwrite && hit)
      begin
        regs[idx]   <= m_pwdata & keep;
        wr_cnt[idx] <= wr_cnt[idx] + 1;
      end
    end
endmodule
`default_nettype wire

// file: tb/test_vsf_host.sv
// self-checking bench for the framing configuration host
`timescale 1ns/1ns
`default_nettype none
module test_vsf_host
  import vsf_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        m_psel;
  logic        m_penable;
  logic [11:0] m_paddr;
  logic        m_pwrite;
  logic [31:0] m_pwdata;
  logic        m_pready;
  logic [31:0] m_prdata;
  logic        m_pslverr;
  logic [3:0]  wait_cycles = 4'h0;
  logic [11:0] err_addr = 12'hFFF;
  logic        async_mode = 1'b0;
  int          fail_count = 0;
  int          n_checks = 0;
  int          cycles = 0;
  always #20 pclk = ~pclk;
  vsf_host #(.DW(40)) vsf_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
    .m_psel(m_psel), .m_penable(m_penable), .m_paddr(m_paddr), .m_pwrite(m_pwrite), .m_pwdata(m_pwdata),
    .m_pready(m_pready), .m_prdata(m_prdata), .m_pslverr(m_pslverr));
  vsf_dev_model vsf_dev_model_i (.pclk(pclk), .presetn(presetn), .m_psel(m_psel), .m_penable(m_penable),
    .m_paddr(m_paddr), .m_pwrite(m_pwrite), .m_pwdata(m_pwdata), .m_pready(m_pready), .m_prdata(m_prdata),
    .m_pslverr(m_pslverr), .wait_cycles(wait_cycles), .err_addr(err_addr), .async_mode(async_mode));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: only the bench timeout ends a hung access
    do
    begin
      @(posedge pclk);
    end
    while (pready_q !== 1'b1);
    r = prdata_q;
    e = pslverr_q;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
    chk({31'h0, e}, 32'h0, "write error flag");
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic e_exp);
    logic [31:0] r;
    logic        e;
    xfer(1'b0, a, 32'h0, r, e);
    chk(r, exp, "read data");
    chk({31'h0, e}, {31'h0, e_exp}, "read error flag");
  endtask
  task automatic run(input logic [31:0] cfg, input logic [31:0] line, input logic [6:0] unit,
                     input logic [23:0] link, input logic [23:0] video, input logic [31:0] st_exp);
    longint      nl, wpl, lc, whole, frac, iw;
    int          n, b0, b1;
    logic [31:0] r;
    logic        e;
    nl    = 1 << cfg[4:3];
    wpl   = (longint'(line[15:0]) * line[23:16] + 15) / 16;
    lc    = wpl + wpl % nl - nl;
    whole = (longint'(link) * unit) / video;
    frac  = ((longint'(link) * unit) % video) * 1000 / video;
    iw    = (whole <= 4) ? 64 : unit - whole;
    b0    = vsf_dev_model_i.wr_cnt[0];
    b1    = vsf_dev_model_i.wr_cnt[1];
    wr(VSF_REG_CFG, cfg);
    wr(VSF_REG_LINE, line);
    wr(VSF_REG_UNIT_SIZE, {25'h0, unit});
    wr(VSF_REG_LINK_BANDWIDTH, {8'h00, link});
    wr(VSF_REG_VIDEO_BANDWIDTH, {8'h00, video});
    wr(VSF_REG_M_VALUE, 32'h005A3C11);
    wr(VSF_REG_N_VALUE, 32'h000FE207);
    wr(VSF_REG_CTRL, 32'h1);
    // a config write while busy must leave the running setup alone
    if (!st_exp[VSF_ST_CFG_ERR])
      wr(VSF_REG_CFG, 32'h0);
    n = 0;
    do
    begin
      xfer(1'b0, VSF_REG_STATUS, 32'h0, r, e);
      n++;
    end
    while (r[VSF_ST_DONE] !== 1'b1 && n < 200);
    chk(r, st_exp, "status");
    if (st_exp[VSF_ST_CFG_ERR])
    begin
      chk(vsf_dev_model_i.wr_cnt[0], b0, "traffic after bad setup");
      return;
    end
    rd(VSF_REG_CFG, cfg, 1'b0);
    rd(VSF_REG_RESULT, {6'h0, frac[9:0], iw[7:0], whole[7:0]}, 1'b0);
    rd(VSF_REG_LANE_CNT, lc[31:0], 1'b0);
    chk(vsf_dev_model_i.regs[0], {29'h0, cfg[10:8]}, "misc");
    chk(vsf_dev_model_i.regs[2], {25'h0, unit & 7'h7E}, "unit size");
    chk(vsf_dev_model_i.regs[4], {29'h0, cfg[2:0]}, "pixel code");
    chk(vsf_dev_model_i.regs[5], lc[31:0], "lane words");
    chk(vsf_dev_model_i.regs[6], {31'h0, cfg[6]}, "interlace");
    chk(vsf_dev_model_i.regs[7], {24'h0, whole[7:0]}, "whole");
    chk(vsf_dev_model_i.regs[8], {22'h0, frac[9:0]}, "fraction");
    chk(vsf_dev_model_i.regs[9], {24'h0, iw[7:0]}, "wait");
    if (cfg[VSF_CFG_SYNC])
    begin
      chk(vsf_dev_model_i.regs[1], 32'h005A3C11, "m written");
      chk(vsf_dev_model_i.regs[3], 32'h000FE207, "n written");
    end
    else
    begin
      chk(vsf_dev_model_i.wr_cnt[1], b1, "m write in async");
      rd(VSF_REG_M_VALUE, 32'h002A4E11, 1'b0);
      rd(VSF_REG_N_VALUE, 32'h0008CA00, 1'b0);
    end
  endtask
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      end_sim;
    end
  end
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(VSF_REG_UNIT_SIZE, 32'h40, 1'b0);
    rd(VSF_REG_CFG, 32'h0, 1'b0);
    rd(VSF_REG_RESULT, 32'h0, 1'b0);
    wr(VSF_REG_STATUS, 32'hF);
    rd(VSF_REG_STATUS, 32'h0, 1'b0);
    rd(8'h2C, 32'h0, 1'b1);
    rd(8'h05, 32'h0, 1'b1);
    run(32'h0000FF6A, 32'h001803E9, 7'h3F, 24'd100, 24'd270, 32'h2);
    wait_cycles <= 4'h3;
    err_addr    <= VSF_DEV_INTERLACE;
    async_mode  <= 1'b1;
    run(32'h00000214, 32'h00080005, 7'h20, 24'd1, 24'd64, 32'hA);
    err_addr <= 12'hFFF;
    run(32'h00000021, 32'h00100007, 7'h21, 24'd100, 24'd200, 32'h2);
    run(32'h00000003, 32'h00100007, 7'h30, 24'd1, 24'd1, 32'h6);
    end_sim;
  end
endmodule
`default_nettype wire
